// ==== hw/status_pkg.sv ====
// Constants shared by the status, event and error queue block
`default_nettype none
package status_pkg;

  // Register offsets (byte addresses within the 256-byte window)
  localparam logic [7:0] OFS_GRP_BASE   = 8'h00;
  localparam logic [7:0] GRP_STRIDE     = 8'h0C;
  localparam logic [7:0] SUB_EVENT      = 8'h00;
  localparam logic [7:0] SUB_ENABLE     = 8'h04;
  localparam logic [7:0] SUB_COND       = 8'h08;
  localparam logic [7:0] OFS_CMD        = 8'h24;
  localparam logic [7:0] OFS_QNEXT      = 8'h28;
  localparam logic [7:0] OFS_QCOUNT     = 8'h2C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h34;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h38;
  localparam logic [7:0] OFS_EN_LIST    = 8'h40;
  localparam logic [7:0] OFS_DIS_LIST   = 8'h60;

  // Command register bit positions
  localparam int CMD_CLS_BIT        = 0;
  localparam int CMD_PRESET_BIT     = 1;
  localparam int CMD_QCLEAR_BIT     = 2;
  localparam int CMD_INST_RESET_BIT = 3;
  localparam int CMD_SYS_PRESET_BIT = 4;

  // Interrupt status bit positions
  localparam int IRQ_MEAS_BIT = 0;
  localparam int IRQ_OPER_BIT = 1;
  localparam int IRQ_QUES_BIT = 2;
  localparam int IRQ_QPUSH_BIT = 3;
  localparam int IRQ_QOVF_BIT = 4;
  localparam int IRQ_W        = 5;

  // Groups and message format
  localparam int NUM_GROUPS     = 3;
  localparam int MSG_W          = 16;
  localparam int LIST_VALID_BIT = 16;
  localparam int LIST_ENTRY_W   = 17;
  localparam int LIST_MAX       = 8;

  // Values after reset
  localparam logic [31:0]      EVENT_RST  = 32'h0000_0000;
  localparam logic [31:0]      ENABLE_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RST    = 5'h00;
  localparam logic [31:0]      RDATA_RST  = 32'h0000_0000;
  localparam logic             HRESP_OKAY = 1'b0;

  // Bus access sequencer
  typedef enum logic {BUS_IDLE, BUS_ACCESS} bus_state_t;

endpackage : status_pkg
`default_nettype wire

// ==== hw/err_stack.sv ====
// Error message store: newest entry is read first, with clear and overflow drop
`default_nettype none
module err_stack #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // Control
  input  wire logic                       push,
  input  wire logic [W-1:0]               push_data,
  input  wire logic                       pop,
  input  wire logic                       clear,
  // State
  output logic      [W-1:0]               top_data,
  output logic      [$clog2(DEPTH+1)-1:0] count,
  output logic                            overflow
);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [DEPTH-1:0][W-1:0] mem_q;
  logic [CW-1:0]           cnt_q;
  logic                    empty;
  logic                    full;

  if (DEPTH < 2) begin : g_bad_depth
    $error("err_stack needs DEPTH of at least 2");
  end

  assign empty    = (cnt_q == '0);
  assign full     = (cnt_q == FULL_CNT);
  assign count    = cnt_q;
  assign top_data = empty ? '0 : mem_q[cnt_q - CW'(1)];
  // Full store drops the newcomer so the history already held stays intact
  assign overflow = push && full && !pop && !clear;

  // Count and storage; a push in the clearing cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      mem_q <= '0;
    end else if (clear) begin
      cnt_q <= push ? CW'(1) : '0;
      if (push) begin
        mem_q[0] <= push_data;
      end
    end else if (pop && !empty) begin
      if (push) begin
        mem_q[cnt_q - CW'(1)] <= push_data; // Replace the popped slot
      end else begin
        cnt_q <= cnt_q - CW'(1);
      end
    end else if (push && !full) begin
      mem_q[cnt_q] <= push_data;
      cnt_q        <= cnt_q + CW'(1);
    end
  end

endmodule // err_stack
`default_nettype wire

// ==== hw/status_block.sv ====
// Status groups, error queue and message filter lists behind an AHB-Lite slave
//
// Behaviour
// R1 - Three groups, each with readable event, read/write enable, readable condition.
// R2 - Condition read returns present condition bits, no latching needed.
// R3 - Events cleared at power-up and clear-status; status preset leaves them.
// R4 - Enables cleared at power-up and status preset; clear-status leaves them.
// R5 - Queue emptied at power-up and clear-status; status preset leaves it.
// R6 - Filter lists cleared only at power-up.
// R7 - Instrument reset and system preset commands alter no status state.
// R8 - Status preset returns status registers to their default states.
// R9 - Queue read returns the most recent message held.
// R10 - Queue clear removes every held message.
// R11 - Host-writable list of codes allowed into the queue, readable back.
// R12 - Host-writable list of codes kept out of the queue, readable back.
// R13 - Event bit latches on condition rising, holds, clears when read.
`default_nettype none
module status_block
  import status_pkg::*;
#(
  parameter int GW        = 16,
  parameter int LIST_LEN  = 8,
  parameter int Q_DEPTH   = 8
) (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Condition inputs from the instrument
  input  wire logic [GW-1:0]        meas_cond,
  input  wire logic [GW-1:0]        oper_cond,
  input  wire logic [GW-1:0]        ques_cond,
  // Message source, same clock
  input  wire logic                 msg_valid,
  input  wire logic [MSG_W-1:0]     msg_code,
  // Summaries and interrupt
  output logic                      meas_summary,
  output logic                      oper_summary,
  output logic                      ques_summary,
  output logic                      irq
);
  localparam int QCW = $clog2(Q_DEPTH+1);

  if (GW < 1 || GW > 32 || LIST_LEN < 1 || LIST_LEN > LIST_MAX || Q_DEPTH < 2) begin : g_bad_param
    $error("status_block parameters out of range");
  end

  // Register offset of one register in a group
  function automatic logic [7:0] grp_ofs(input int g, input logic [7:0] sub);
    grp_ofs = OFS_GRP_BASE + 8'(g) * GRP_STRIDE + sub;
  endfunction

  // Code match against a filter list
  function automatic logic in_list(input logic [LIST_LEN-1:0][LIST_ENTRY_W-1:0] lst,
                                   input logic [MSG_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < LIST_LEN; i++) begin
      if (lst[i][LIST_VALID_BIT] && lst[i][MSG_W-1:0] == code) begin
        hit = 1'b1;
      end
    end
    in_list = hit;
  endfunction

  // Whether a filter list holds any valid entry
  function automatic logic list_any(input logic [LIST_LEN-1:0][LIST_ENTRY_W-1:0] lst);
    logic any;
    any = 1'b0;
    for (int i = 0; i < LIST_LEN; i++) begin
      any = any | lst[i][LIST_VALID_BIT];
    end
    list_any = any;
  endfunction

  // Bus sequencer state
  bus_state_t  bus_state_q;
  logic [7:0]  addr_q;
  logic        wr_q;
  logic        hit_q;
  logic        hreadyout_q;
  logic [31:0] hrdata_q;
  logic        wr_stb;
  logic        rd_stb;

  // Group state
  logic [NUM_GROUPS-1:0][GW-1:0] cond_in;
  logic [NUM_GROUPS-1:0][GW-1:0] cond_s1_q;
  logic [NUM_GROUPS-1:0][GW-1:0] cond_q;
  logic [NUM_GROUPS-1:0][GW-1:0] cond_prev_q;
  logic [NUM_GROUPS-1:0][GW-1:0] event_q;
  logic [NUM_GROUPS-1:0][GW-1:0] enable_q;
  logic [NUM_GROUPS-1:0][GW-1:0] ev_set;
  logic [NUM_GROUPS-1:0]         summary_q;

  // Commands
  logic cmd_wr;
  logic cls;
  logic preset;
  logic qclear;

  // Filter lists and queue
  logic [LIST_LEN-1:0][LIST_ENTRY_W-1:0] en_list_q;
  logic [LIST_LEN-1:0][LIST_ENTRY_W-1:0] dis_list_q;
  logic                                  admit;
  logic                                  q_push;
  logic                                  q_pop;
  logic [MSG_W-1:0]                      q_top;
  logic [QCW-1:0]                        q_count;
  logic                                  q_ovf;

  // Interrupt state
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_enable_q;
  logic [IRQ_W-1:0] irq_set;
  logic             irq_q;

  // Read path
  logic [31:0] rd_data;

  assign hrdata       = hrdata_q;
  assign hreadyout    = hreadyout_q;
  assign hresp        = HRESP_OKAY;
  assign meas_summary = summary_q[0];
  assign oper_summary = summary_q[1];
  assign ques_summary = summary_q[2];
  assign irq          = irq_q;

  // Every transfer gets one wait state, so the access works on hwdata and
  // read data is registered, at the cost of half the bus throughput
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_q <= BUS_IDLE;
      addr_q      <= 8'h00;
      wr_q        <= 1'b0;
      hit_q       <= 1'b0;
      hreadyout_q <= 1'b1;
    end else begin
      unique case (bus_state_q)
        BUS_IDLE: begin
          if (hsel && htrans[1] && hready) begin
            addr_q      <= haddr[7:0];
            wr_q        <= hwrite;
            hit_q       <= (haddr[31:8] == 24'h000000); // Outside window: reads 0, writes dropped
            hreadyout_q <= 1'b0;
            bus_state_q <= BUS_ACCESS;
          end
        end
        BUS_ACCESS: begin
          hreadyout_q <= 1'b1;
          bus_state_q <= BUS_IDLE;
        end
      endcase
    end
  end

  assign wr_stb = (bus_state_q == BUS_ACCESS) && wr_q && hit_q;
  assign rd_stb = (bus_state_q == BUS_ACCESS) && !wr_q && hit_q;

  // Command decode; reset and system preset bits are accepted and touch nothing
  assign cmd_wr = wr_stb && (addr_q == OFS_CMD); // R7
  assign cls    = cmd_wr && hwdata[CMD_CLS_BIT];
  assign preset = cmd_wr && hwdata[CMD_PRESET_BIT]; // R8
  assign qclear = cls || (cmd_wr && hwdata[CMD_QCLEAR_BIT]); // R5 R10

  assign cond_in[0] = meas_cond;
  assign cond_in[1] = oper_cond;
  assign cond_in[2] = ques_cond;

  // Per group condition, event and enable registers
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
    // Two-stage synchroniser, then a delayed copy for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cond_s1_q[g]   <= '0;
        cond_q[g]      <= '0;
        cond_prev_q[g] <= '0;
      end else begin
        cond_s1_q[g]   <= cond_in[g];
        cond_q[g]      <= cond_s1_q[g]; // R2
        cond_prev_q[g] <= cond_q[g];
      end
    end

    assign ev_set[g] = cond_q[g] & ~cond_prev_q[g]; // R13

    // Sticky events; a new edge in the clearing cycle still lands
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        event_q[g] <= EVENT_RST[GW-1:0]; // R3
      end else if (cls || (rd_stb && addr_q == grp_ofs(g, SUB_EVENT))) begin
        event_q[g] <= ev_set[g]; // R3 R13
      end else begin
        event_q[g] <= event_q[g] | ev_set[g]; // R13
      end
    end

    // Enable mask, untouched by clear-status
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        enable_q[g] <= ENABLE_RST[GW-1:0]; // R4
      end else if (preset) begin
        enable_q[g] <= ENABLE_RST[GW-1:0]; // R4 R8
      end else if (wr_stb && addr_q == grp_ofs(g, SUB_ENABLE)) begin
        enable_q[g] <= hwdata[GW-1:0]; // R1
      end
    end

    // Group summary
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        summary_q[g] <= 1'b0;
      end else begin
        summary_q[g] <= |(event_q[g] & enable_q[g]);
      end
    end
  end

  // Filter lists, cleared only by power-up reset
  for (genvar i = 0; i < LIST_LEN; i++) begin : g_list
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        en_list_q[i]  <= '0; // R6
        dis_list_q[i] <= '0; // R6
      end else begin
        if (wr_stb && addr_q == OFS_EN_LIST + 8'(i * 4)) begin
          en_list_q[i] <= hwdata[LIST_ENTRY_W-1:0]; // R11
        end
        if (wr_stb && addr_q == OFS_DIS_LIST + 8'(i * 4)) begin
          dis_list_q[i] <= hwdata[LIST_ENTRY_W-1:0]; // R12
        end
      end
    end
  end

  // An empty allow list admits every code; the block list always wins
  assign admit  = (!list_any(en_list_q) || in_list(en_list_q, msg_code)) // R11
                  && !in_list(dis_list_q, msg_code); // R12
  assign q_push = msg_valid && admit;
  assign q_pop  = rd_stb && (addr_q == OFS_QNEXT) && (q_count != '0); // R9

  // Message store
  err_stack #(
    .W     (MSG_W),
    .DEPTH (Q_DEPTH)
  ) u_err_stack (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .push      (q_push),
    .push_data (msg_code),
    .pop       (q_pop),
    .clear     (qclear), // R5 R10
    .top_data  (q_top),
    .count     (q_count),
    .overflow  (q_ovf)
  );

  // Interrupt events
  assign irq_set[IRQ_MEAS_BIT]  = |ev_set[0];
  assign irq_set[IRQ_OPER_BIT]  = |ev_set[1];
  assign irq_set[IRQ_QUES_BIT]  = |ev_set[2];
  assign irq_set[IRQ_QPUSH_BIT] = q_push && !q_ovf;
  assign irq_set[IRQ_QOVF_BIT]  = q_ovf;

  // Sticky interrupt status; set beats a simultaneous clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_q <= IRQ_RST;
    end else if (wr_stb && addr_q == OFS_IRQ_CLEAR) begin
      irq_status_q <= (irq_status_q & ~hwdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status_q <= irq_status_q | irq_set;
    end
  end

  // Interrupt enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_q <= IRQ_RST;
    end else if (wr_stb && addr_q == OFS_IRQ_ENABLE) begin
      irq_enable_q <= hwdata[IRQ_W-1:0];
    end
  end

  // Level interrupt, registered so the pin is glitch free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_q & irq_enable_q);
    end
  end

  // Read multiplexer; write-only and unmapped words read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (addr_q == grp_ofs(g, SUB_EVENT)) begin
        rd_data[GW-1:0] = event_q[g]; // R1
      end
      if (addr_q == grp_ofs(g, SUB_ENABLE)) begin
        rd_data[GW-1:0] = enable_q[g]; // R1
      end
      if (addr_q == grp_ofs(g, SUB_COND)) begin
        rd_data[GW-1:0] = cond_q[g]; // R2
      end
    end
    for (int i = 0; i < LIST_LEN; i++) begin
      if (addr_q == OFS_EN_LIST + 8'(i * 4)) begin
        rd_data[LIST_ENTRY_W-1:0] = en_list_q[i]; // R11
      end
      if (addr_q == OFS_DIS_LIST + 8'(i * 4)) begin
        rd_data[LIST_ENTRY_W-1:0] = dis_list_q[i]; // R12
      end
    end
    if (addr_q == OFS_QNEXT) begin
      rd_data[MSG_W-1:0] = q_top; // R9
    end
    if (addr_q == OFS_QCOUNT) begin
      rd_data[QCW-1:0] = q_count;
    end
    if (addr_q == OFS_IRQ_STATUS) begin
      rd_data[IRQ_W-1:0] = irq_status_q;
    end
    if (addr_q == OFS_IRQ_ENABLE) begin
      rd_data[IRQ_W-1:0] = irq_enable_q;
    end
  end

  // Read data register, held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= RDATA_RST;
    end else if (bus_state_q == BUS_ACCESS && !wr_q) begin
      hrdata_q <= hit_q ? rd_data : RDATA_RST;
    end
  end

endmodule // status_block
`default_nettype wire

// ==== tb/status_block_props.sv ====
// Checker of bus timing and quiet outputs of the status block
`default_nettype none
module status_block_props
  import status_pkg::*;
#(
  parameter int GW = 16
) (
  // Clock and reset
  input wire logic          hclk,
  input wire logic          hresetn,
  // Bus
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic          hready,
  input wire logic [31:0]   hrdata,
  input wire logic          hreadyout,
  input wire logic          hresp,
  // Instrument side
  input wire logic [GW-1:0] meas_cond,
  input wire logic          meas_summary,
  input wire logic          oper_summary,
  input wire logic          ques_summary,
  input wire logic          irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic rd_pend_q;
  logic wr_seen_q;
  // Address phase accepted
  assign take = hsel && htrans[1] && hready && hreadyout;
  // Read in flight, and any write since reset (enables can only be nonzero after one)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_q <= 1'b0;
      wr_seen_q <= 1'b0;
    end else begin
      rd_pend_q <= take && !hwrite;
      wr_seen_q <= wr_seen_q || (take && hwrite);
    end
  end
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_out_rd;
    take && !hwrite && (haddr[31:8] != 24'h00_0000);
  endsequence
  // Pin steady over the sync stages before and during the read
  sequence s_cond_rd;
    take && !hwrite && haddr == 32'h0000_0008 && $stable(meas_cond)
      && $past(meas_cond, 2) == meas_cond && $past(meas_cond, 3) == meas_cond ##1 $stable(meas_cond);
  endsequence
  AST_ONE_WAIT:
    assert property (take |=> s_wait) else $error("wait state not exactly one cycle");
  AST_READY_SOLO:
    assert property (!hreadyout |=> hreadyout) else $error("hreadyout low two cycles");
  AST_HRESP_OKAY:
    assert property (hresp == HRESP_OKAY) else $error("response not okay");
  AST_HRDATA_HOLD:
    assert property (!rd_pend_q |=> $stable(hrdata)) else $error("read data moved without a read");
  AST_OUT_RD_ZERO:
    assert property (s_out_rd |-> ##2 hrdata == RDATA_RST) else $error("unmapped read not zero");
  AST_COND_NOW:
    assert property (s_cond_rd |-> ##1 hrdata == 32'($past(meas_cond))) else $error("condition read stale");
  AST_IRQ_QUIET:
    assert property (!wr_seen_q |-> !irq) else $error("irq with enables cleared");
  AST_SUM_QUIET:
    assert property (!wr_seen_q |-> !(meas_summary || oper_summary || ques_summary))
      else $error("summary with enables cleared");
endmodule // status_block_props
bind status_block status_block_props #(.GW(GW)) props_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .meas_cond(meas_cond), .meas_summary(meas_summary), .oper_summary(oper_summary),
  .ques_summary(ques_summary), .irq(irq));
`default_nettype wire

// ==== tb/status_host.sv ====
// Remote host model issuing single word bus transfers
`default_nettype none
module status_host (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Bus master side
  output var logic         hsel,
  output var logic [31:0]  haddr,
  output var logic [1:0]   htrans,
  output var logic         hwrite,
  output var logic [2:0]   hsize,
  output var logic [31:0]  hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Wait limit used up
  output var logic         hung
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    hung = 1'b0;
  end
  // Bounded wait for hready sampled high at an edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) hung <= 1'b1;
  endtask
  // One transfer; released lines show inverted values so stale data is never mistaken
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    haddr <= ~a;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule // status_host
`default_nettype wire

// ==== tb/test_status_block.sv ====
// Self-checking bench for the status, event and error queue block
`default_nettype none
module test_status_block
  import status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, msg_valid, irq, hung;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize, sum;
  logic [15:0] cond_q [3];
  logic [15:0] msg_code;
  int          n_fail, tests_run;
  // Single slave drives the bus ready
  assign hready = hreadyout;
  status_block dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .meas_cond(cond_q[0]), .oper_cond(cond_q[1]), .ques_cond(cond_q[2]),
    .msg_valid(msg_valid), .msg_code(msg_code), .meas_summary(sum[0]), .oper_summary(sum[1]),
    .ques_summary(sum[2]), .irq(irq));
  status_host host_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hung(hung));
  // Clock
  initial hclk = 1'b0;
  always #50 hclk = ~hclk;
  // A hung bus ends the run
  always @(posedge hung) begin
    n_fail++;
    close_out();
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [31:0] ra(input logic [7:0] o);
    return {24'h00_0000, o};
  endfunction
  function automatic logic [31:0] ga(input int g, input logic [7:0] s);
    return ra(8'(GRP_STRIDE * g) + s);
  endfunction
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
    host_u.xfer(1'b0, a, 32'h0000_0000, q);
    chk(nm, q, e);
  endtask
  task automatic cmd(input int b);
    wr(ra(OFS_CMD), 32'h0000_0001 << b);
  endtask
  // One-cycle message offer
  task automatic push(input logic [15:0] c);
    msg_valid <= 1'b1;
    msg_code <= c;
    @(posedge hclk);
    msg_valid <= 1'b0;
    @(posedge hclk);
  endtask
  // Condition change, then time for sync, event and summary
  task automatic rise(input int g, input logic [15:0] v);
    cond_q[g] <= v;
    repeat (6) @(posedge hclk);
  endtask
  initial begin
    hresetn = 1'b0;
    msg_valid = 1'b0;
    msg_code = 16'h0000;
    cond_q = '{16'h0000, 16'h0000, 16'h0000};
    n_fail = 0;
    tests_run = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Power-up state
    for (int g = 0; g < NUM_GROUPS; g++) begin
      rd("event", ga(g, SUB_EVENT), EVENT_RST);
      rd("enable", ga(g, SUB_ENABLE), ENABLE_RST);
    end
    rd("count", ra(OFS_QCOUNT), 32'h0000_0000);
    rd("allow", ra(OFS_EN_LIST), 32'h0000_0000);
    rd("block", ra(OFS_DIS_LIST), 32'h0000_0000);
    $display("test reset done");
    // Enables read back, unmapped and write-only places
    for (int g = 0; g < NUM_GROUPS; g++) wr(ga(g, SUB_ENABLE), 32'h0000_FF0F);
    wr(32'h0000_0104, 32'h0000_FFFF);
    for (int g = 0; g < NUM_GROUPS; g++) rd("enable", ga(g, SUB_ENABLE), 32'h0000_FF0F);
    rd("unmapped", 32'h0000_0104, 32'h0000_0000);
    rd("command", ra(OFS_CMD), 32'h0000_0000);
    $display("test enable done");
    // Event latch and read clear per group
    for (int g = 0; g < NUM_GROUPS; g++) begin
      rise(g, 16'h0005);
      chk("summary", {29'h0, sum}, 32'(3'h1 << g));
      rd("cond", ga(g, SUB_COND), 32'h0000_0005);
      rd("event", ga(g, SUB_EVENT), 32'h0000_0005);
      rd("event", ga(g, SUB_EVENT), 32'h0000_0000);
      chk("summary", {31'h0, sum[g]}, 32'h0000_0000);
    end
    $display("test event done");
    // Interrupt raise, mask, clear
    wr(ra(OFS_IRQ_CLEAR), 32'h0000_001F);
    wr(ra(OFS_IRQ_ENABLE), 32'h0000_0001);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    rise(0, 16'h0007);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    wr(ra(OFS_IRQ_ENABLE), 32'h0000_0000);
    // Pin is registered one edge after the mask lands
    @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h0000_0000);
    rd("irqstat", ra(OFS_IRQ_STATUS), 32'h0000_0001);
    wr(ra(OFS_IRQ_CLEAR), 32'h0000_001F);
    rd("irqstat", ra(OFS_IRQ_STATUS), 32'h0000_0000);
    rd("event", ga(0, SUB_EVENT), 32'h0000_0002);
    $display("test irq done");
    // Queue newest first and clear
    for (int i = 1; i <= 3; i++) push(16'h0100 + 16'(i));
    rd("count", ra(OFS_QCOUNT), 32'h0000_0003);
    rd("next", ra(OFS_QNEXT), 32'h0000_0103);
    rd("count", ra(OFS_QCOUNT), 32'h0000_0002);
    cmd(CMD_QCLEAR_BIT);
    rd("count", ra(OFS_QCOUNT), 32'h0000_0000);
    rd("next", ra(OFS_QNEXT), 32'h0000_0000);
    $display("test queue done");
    // Status preset, clear-status, and the two commands with no effect
    rise(1, 16'h0007);
    wr(ga(1, SUB_ENABLE), 32'h0000_00F0);
    push(16'h0201);
    push(16'h0202);
    cmd(CMD_PRESET_BIT);
    rd("enable", ga(1, SUB_ENABLE), 32'h0000_0000);
    rd("count", ra(OFS_QCOUNT), 32'h0000_0002);
    rd("event", ga(1, SUB_EVENT), 32'h0000_0002);
    rise(1, 16'h000F);
    wr(ga(1, SUB_ENABLE), 32'h0000_00F0);
    cmd(CMD_CLS_BIT);
    rd("event", ga(1, SUB_EVENT), 32'h0000_0000);
    rd("count", ra(OFS_QCOUNT), 32'h0000_0000);
    rd("enable", ga(1, SUB_ENABLE), 32'h0000_00F0);
    push(16'h0203);
    rise(2, 16'h0007);
    cmd(CMD_INST_RESET_BIT);
    cmd(CMD_SYS_PRESET_BIT);
    rd("enable", ga(1, SUB_ENABLE), 32'h0000_00F0);
    rd("count", ra(OFS_QCOUNT), 32'h0000_0001);
    rd("event", ga(2, SUB_EVENT), 32'h0000_0002);
    $display("test command done");
    // Full queue keeps its history, drops the newcomer and flags it
    cmd(CMD_QCLEAR_BIT);
    wr(ra(OFS_IRQ_CLEAR), 32'h0000_001F);
    for (int i = 1; i <= 9; i++) push(16'h0300 + 16'(i));
    rd("count", ra(OFS_QCOUNT), 32'h0000_0008);
    rd("irqstat", ra(OFS_IRQ_STATUS), 32'h0000_0018);
    rd("next", ra(OFS_QNEXT), 32'h0000_0308);
    $display("test overflow done");
    // Message lists: block wins over allow, unlisted code kept out
    wr(ra(OFS_EN_LIST), 32'h0001_0011);
    wr(ra(OFS_EN_LIST + 8'h04), 32'h0001_0022);
    wr(ra(OFS_DIS_LIST + 8'h1C), 32'h0001_0022);
    cmd(CMD_QCLEAR_BIT);
    push(16'h0022);
    push(16'h0033);
    push(16'h0011);
    rd("count", ra(OFS_QCOUNT), 32'h0000_0001);
    rd("next", ra(OFS_QNEXT), 32'h0000_0011);
    for (int b = 0; b < 5; b++) cmd(b);
    rd("allow", ra(OFS_EN_LIST), 32'h0001_0011);
    rd("allow", ra(OFS_EN_LIST + 8'h04), 32'h0001_0022);
    rd("block", ra(OFS_DIS_LIST + 8'h1C), 32'h0001_0022);
    $display("test lists done");
    close_out();
  end
endmodule // test_status_block
`default_nettype wire
